// >>> rtl/mic_pkg.sv
`default_nettype none
package mic_pkg;
   // Terminal layout
   localparam int NUM_TERM   = 15;
   localparam int LOW_TERMS  = 11;
   localparam int HIGH_LSB   = 11;
   localparam int FUNC_W     = 4;
   localparam int MS_W       = 10;
   localparam int ADDR_W     = 8;
   localparam int NUM_FAULT  = 5;

   // Timing: one millisecond of pclk
   localparam int CLK_PERIOD_NS = 100;
   localparam int MS_NS         = 1000000;
   localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_STATE_LOW  = 8'h00;
   localparam logic [7:0] OFF_STATE_HIGH = 8'h04;
   localparam logic [7:0] OFF_POL_LOW    = 8'h08;
   localparam logic [7:0] OFF_POL_HIGH   = 8'h0C;
   localparam logic [7:0] OFF_FILT_MS    = 8'h10;
   localparam logic [7:0] OFF_VALID_MS   = 8'h14;
   localparam logic [7:0] OFF_FUNC_LOW   = 8'h18;
   localparam logic [7:0] OFF_FUNC_HIGH  = 8'h1C;
   localparam logic [7:0] OFF_KEY_POL    = 8'h20;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h28;
   localparam logic [7:0] OFF_FAULT      = 8'h2C;

   // Reset values and limits, in milliseconds
   localparam logic [MS_W-1:0] FILT_MS_RESET  = 10'h00F;
   localparam logic [MS_W-1:0] FILT_MS_MIN    = 10'h002;
   localparam logic [MS_W-1:0] FILT_MS_MAX    = 10'h3E8;
   localparam logic [MS_W-1:0] VALID_MS_RESET = 10'h00A;

   // Interrupt status bit positions
   localparam int IRQ_CHANGE = 0;
   localparam int IRQ_TRIP   = 1;
   localparam int IRQ_WARN   = 2;
   localparam int IRQ_W      = 3;

   // Fault cause bit positions
   localparam int FLT_XFMR  = 0;
   localparam int FLT_MOTOR = 1;
   localparam int FLT_FAN   = 2;
   localparam int FLT_EXT1  = 3;
   localparam int FLT_EXT2  = 4;

   typedef enum logic [FUNC_W-1:0] {
      FN_NONE,
      FN_ANALOG_HOLD,
      FN_ANALOG_SWAP,
      FN_LOCAL_REMOTE_SELECT,
      FN_RAMP_FREEZE,
      FN_DOOR_OPEN,
      FN_TRANSFORMER_HEAT_WARNING,
      FN_TRANSFORMER_HEAT_TRIP,
      FN_MOTOR_HEAT_TRIP,
      FN_FAN_FAULT_TRIP,
      FN_EXTERNAL_FAULT_ONE,
      FN_EXTERNAL_FAULT_TWO,
      FN_HIGH_VOLTAGE,
      FN_RUN_PERMIT,
      FN_CONTROL_POWER
   } mic_func_t;

   typedef logic [MS_W-1:0] mic_ms_t;
endpackage
`default_nettype wire

// >>> rtl/mic_cond_if.sv
`default_nettype none
interface mic_cond_if;
   import mic_pkg::*;
   logic [NUM_TERM-1:0] pol;
   mic_ms_t             filt_ms;
   mic_ms_t             valid_ms;
   logic                ms_tick;
   logic [NUM_TERM-1:0] qual;
   modport ctrl (output pol, filt_ms, valid_ms, ms_tick, input qual);
   modport cond (input pol, filt_ms, valid_ms, ms_tick, output qual);
endinterface
`default_nettype wire

// >>> rtl/mic_ms_tick.sv
`default_nettype none
module mic_ms_tick #(
   parameter int CYC_PER_MS = mic_pkg::CYC_PER_MS
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // One-cycle pulse every millisecond
   output logic      tick
);
   import mic_pkg::*;
   localparam int CW = $clog2(CYC_PER_MS + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC_PER_MS - 1);

   logic [CW-1:0] cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else if (cnt == LAST) begin
         cnt  <= '0;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + CW'(1);
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/mic_term_cond.sv
`default_nettype none
module mic_term_cond (
   // Clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // Raw contact levels
   input  wire logic [mic_pkg::NUM_TERM-1:0] term_raw,
   // Settings in, qualified states out
   mic_cond_if.cond                       cif
);
   import mic_pkg::*;

   for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
      logic    inv;
      logic    filt;
      logic    qual;
      logic    pend;
      mic_ms_t fcnt;
      mic_ms_t vcnt;

      // Polarity ahead of the filter so NC contacts filter like NO ones
      assign inv = term_raw[t] ^ cif.pol[t];

      // Level must stand unchanged for the whole filter time
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            filt <= 1'b0;
            fcnt <= '0;
         end else if (inv == filt) begin
            fcnt <= '0;
         end else if (cif.ms_tick) begin
            if ({1'b0, fcnt} + 11'h001 >= {1'b0, cif.filt_ms}) begin
               filt <= inv;
               fcnt <= '0;
            end else begin
               fcnt <= fcnt + 10'h001;
            end
         end
      end

      // First change starts the window; state at its end is taken
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            qual <= 1'b0;
            pend <= 1'b0;
            vcnt <= '0;
         end else if (!pend) begin
            if (filt != qual) begin
               if (cif.valid_ms == '0) begin
                  qual <= filt;
               end else begin
                  pend <= 1'b1;
                  vcnt <= '0;
               end
            end
         end else if (cif.ms_tick) begin
            if ({1'b0, vcnt} + 11'h001 >= {1'b0, cif.valid_ms}) begin
               qual <= filt;
               pend <= 1'b0;
            end else begin
               vcnt <= vcnt + 10'h001;
            end
         end
      end

      assign cif.qual[t] = qual;
   end
endmodule
`default_nettype wire

// >>> rtl/mic_top.sv
// Summary of operation
// - With analog source, an on hold terminal freezes the analog value.
// - Combined analog mode uses voltage, or current while swap is on.
// - Local/remote on while stopped picks manual sources; settings stay.
// - While ramp freeze is on, ramping halts at the present frequency.
// - Any on trip terminal blocks output and flags its cause.
// - The transformer heat warning only warns and never blocks output.
// - With run permit assigned, run commands execute only while it is on.
// - States 0-10 in bits 0-10 of one word, 11-14 in bits 11-14 of another.
// - Filter time is 2 to 1000 ms, 15 ms by default; longer is slower.
// - Per-terminal polarity bit, 0 open and 1 closed, split over two words.
// - Keypad inputs get a selectable normally-open or closed contact type.
// - A first change starts a valid timer; changes inside it are ignored.
`default_nettype none
module mic_top #(
   parameter int CYC_PER_MS = mic_pkg::CYC_PER_MS,
   parameter int AN_W       = 12,
   parameter int KEY_W      = 4
) (
   // Clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // APB slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [mic_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   output logic                              irq,
   // Contacts
   input  wire logic [mic_pkg::NUM_TERM-1:0] term_raw,
   input  wire logic [KEY_W-1:0]             keypad_raw,
   output logic      [KEY_W-1:0]             keypad_on,
   // Drive core inputs
   input  wire logic [AN_W-1:0]              voltage_analog_input,
   input  wire logic [AN_W-1:0]              current_analog_input,
   input  wire logic                         analog_source,
   input  wire logic                         combined_analog_mode,
   input  wire logic                         current_only_mode,
   input  wire logic                         drive_running,
   input  wire logic                         run_cmd,
   // Drive core outputs
   output logic      [AN_W-1:0]              analog_freq,
   output logic                              source_manual,
   output logic                              ramp_freeze,
   output logic                              output_block,
   output logic      [mic_pkg::NUM_FAULT-1:0] fault_cause,
   output logic                              transformer_heat_warning,
   output logic                              run_execute,
   output logic      [mic_pkg::NUM_TERM-1:0] func_active
);
   import mic_pkg::*;

   mic_cond_if cif ();

   logic [NUM_TERM-1:0]        pol;
   mic_ms_t                    filt_ms;
   mic_ms_t                    valid_ms;
   logic [NUM_TERM*FUNC_W-1:0] func_cfg;
   logic [KEY_W-1:0]           key_pol;
   logic [IRQ_W-1:0]           irq_status;
   logic [IRQ_W-1:0]           irq_mask;
   logic [NUM_TERM-1:0]        qual;
   logic [NUM_TERM-1:0]        qual_d;
   logic [NUM_TERM-1:0]        fn_on;
   logic [NUM_TERM-1:0]        fn_assigned;
   logic [31:0]                rd_mux;
   logic                       mapped;
   logic                       wr_en;
   logic                       rd_status;
   logic                       block_d;
   logic                       warn_d;
   logic [AN_W-1:0]            analog_live;
   logic [NUM_FAULT-1:0]       next_fault;
   logic [IRQ_W-1:0]           events;

   mic_ms_tick #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (cif.ms_tick)
   );

   mic_term_cond u_cond (
      .pclk     (pclk),
      .presetn  (presetn),
      .term_raw (term_raw),
      .cif      (cif.cond)
   );

   assign cif.pol      = pol;
   assign cif.filt_ms  = filt_ms;
   assign cif.valid_ms = valid_ms;
   assign qual         = cif.qual;

   // APB: zero wait states, so every access ends in its first access cycle
   assign pready    = 1'b1;
   assign wr_en     = psel & penable & pwrite & mapped;
   assign rd_status = psel & penable & ~pwrite & (paddr == OFF_IRQ_STATUS);
   assign pslverr   = psel & penable & ~mapped;

   always_comb begin
      rd_mux = '0;
      mapped = 1'b1;
      case (paddr)
         OFF_STATE_LOW:  rd_mux[LOW_TERMS-1:0] = qual[LOW_TERMS-1:0];
         OFF_STATE_HIGH: rd_mux[NUM_TERM-1:HIGH_LSB] =
                            qual[NUM_TERM-1:HIGH_LSB];
         OFF_POL_LOW:    rd_mux[LOW_TERMS-1:0] = pol[LOW_TERMS-1:0];
         OFF_POL_HIGH:   rd_mux[NUM_TERM-1:HIGH_LSB] = pol[NUM_TERM-1:HIGH_LSB];
         OFF_FILT_MS:    rd_mux[MS_W-1:0] = filt_ms;
         OFF_VALID_MS:   rd_mux[MS_W-1:0] = valid_ms;
         OFF_FUNC_LOW:   rd_mux = func_cfg[31:0];
         OFF_FUNC_HIGH:  rd_mux[27:0] = func_cfg[59:32];
         OFF_KEY_POL:    rd_mux[KEY_W-1:0] = key_pol;
         OFF_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status;
         OFF_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask;
         OFF_FAULT:      rd_mux[NUM_FAULT-1:0] = fault_cause;
         default:        mapped = 1'b0;
      endcase
   end

   // Read data caught in the setup cycle and held through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel & ~penable) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol <= '0;
      end else if (wr_en && paddr == OFF_POL_LOW) begin
         pol[LOW_TERMS-1:0] <= pwdata[LOW_TERMS-1:0];
      end else if (wr_en && paddr == OFF_POL_HIGH) begin
         pol[NUM_TERM-1:HIGH_LSB] <= pwdata[NUM_TERM-1:HIGH_LSB];
      end
   end

   // Out-of-range filter times are clamped rather than refused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_ms <= FILT_MS_RESET;
      end else if (wr_en && paddr == OFF_FILT_MS) begin
         if (pwdata[31:0] < 32'(FILT_MS_MIN)) begin
            filt_ms <= FILT_MS_MIN;
         end else if (pwdata[31:0] > 32'(FILT_MS_MAX)) begin
            filt_ms <= FILT_MS_MAX;
         end else begin
            filt_ms <= pwdata[MS_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_ms <= VALID_MS_RESET;
      end else if (wr_en && paddr == OFF_VALID_MS) begin
         valid_ms <= pwdata[MS_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_cfg <= '0;
      end else if (wr_en && paddr == OFF_FUNC_LOW) begin
         func_cfg[31:0] <= pwdata;
      end else if (wr_en && paddr == OFF_FUNC_HIGH) begin
         func_cfg[59:32] <= pwdata[27:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_pol <= '0;
      end else if (wr_en && paddr == OFF_KEY_POL) begin
         key_pol <= pwdata[KEY_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= '0;
      end else if (wr_en && paddr == OFF_IRQ_MASK) begin
         irq_mask <= pwdata[IRQ_W-1:0];
      end
   end

   // Keypad contacts share the terminal polarity convention
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         keypad_on <= '0;
      end else begin
         keypad_on <= keypad_raw ^ key_pol;
      end
   end

   // Per-function OR of every on terminal assigned to it
   for (genvar f = 0; f < NUM_TERM; f++) begin : g_func
      logic [NUM_TERM-1:0] match;
      for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
         assign match[t] = func_cfg[t*FUNC_W +: FUNC_W] == FUNC_W'(f);
      end
      assign fn_on[f]       = |(match & qual);
      assign fn_assigned[f] = |match;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_active <= '0;
      end else begin
         func_active <= fn_on;
      end
   end

   always_comb begin
      if ((combined_analog_mode && fn_on[FN_ANALOG_SWAP]) ||
          (!combined_analog_mode && current_only_mode)) begin
         analog_live = current_analog_input;
      end else begin
         analog_live = voltage_analog_input;
      end
   end

   // Holding means simply not reloading, so the value at the edge stays
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_freq <= '0;
      end else if (!(analog_source && fn_on[FN_ANALOG_HOLD])) begin
         analog_freq <= analog_live;
      end
   end

   // Source switching only follows the terminal while stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_manual <= 1'b0;
      end else if (!drive_running) begin
         source_manual <= fn_on[FN_LOCAL_REMOTE_SELECT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_freeze <= 1'b0;
      end else begin
         ramp_freeze <= fn_on[FN_RAMP_FREEZE];
      end
   end

   always_comb begin
      next_fault            = '0;
      next_fault[FLT_XFMR]  = fn_on[FN_TRANSFORMER_HEAT_TRIP];
      next_fault[FLT_MOTOR] = fn_on[FN_MOTOR_HEAT_TRIP];
      next_fault[FLT_FAN]   = fn_on[FN_FAN_FAULT_TRIP];
      next_fault[FLT_EXT1]  = fn_on[FN_EXTERNAL_FAULT_ONE];
      next_fault[FLT_EXT2]  = fn_on[FN_EXTERNAL_FAULT_TWO];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_cause  <= '0;
         output_block <= 1'b0;
      end else begin
         fault_cause  <= next_fault;
         output_block <= |next_fault;
      end
   end

   // Warning is kept out of the block path on purpose
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transformer_heat_warning <= 1'b0;
      end else begin
         transformer_heat_warning <=
            fn_on[FN_TRANSFORMER_HEAT_WARNING];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_execute <= 1'b0;
      end else begin
         run_execute <= run_cmd & (~fn_assigned[FN_RUN_PERMIT] |
                                   fn_on[FN_RUN_PERMIT]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qual_d  <= '0;
         block_d <= 1'b0;
         warn_d  <= 1'b0;
      end else begin
         qual_d  <= qual;
         block_d <= output_block;
         warn_d  <= transformer_heat_warning;
      end
   end

   always_comb begin
      events             = '0;
      events[IRQ_CHANGE] = |(qual ^ qual_d);
      events[IRQ_TRIP]   = output_block & ~block_d;
      events[IRQ_WARN]   = transformer_heat_warning & ~warn_d;
   end

   // Clear only what the reader saw, and a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
      end else if (rd_status) begin
         irq_status <= (irq_status & ~prdata[IRQ_W-1:0]) | events;
      end else begin
         irq_status <= irq_status | events;
      end
   end

   assign irq = |(irq_status & irq_mask);
endmodule
`default_nettype wire

// >>> rtl/_unused_placeholder_do_not_compile.sv
`default_nettype none
`default_nettype wire

// >>> verif/mic_contacts.sv
`default_nettype none
module mic_contacts (
   // Clock
   input  wire logic        pclk,
   // Contact positions and bounce request
   input  wire logic [14:0] closed,
   input  wire logic        chatter,
   // Levels at the terminals
   output logic      [14:0] term_raw
);
   timeunit 1ns;
   timeprecision 1ns;
   initial term_raw = 15'h0000;
   // A bouncing contact flips every cycle, so no level outlasts a filter
   always @(posedge pclk) begin
      term_raw <= chatter ? (term_raw ^ closed) : closed;
   end
endmodule
`default_nettype wire

// >>> verif/mic_top_checker.sv
`default_nettype none
module mic_checker #(
   parameter int AN_W = 12
) (
   // Clock, reset and bus
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic [7:0]      paddr,
   input wire logic [31:0]     prdata,
   input wire logic            pslverr,
   // Drive core side
   input wire logic [AN_W-1:0] voltage_analog_input,
   input wire logic [AN_W-1:0] current_analog_input,
   input wire logic            analog_source,
   input wire logic [AN_W-1:0] analog_freq,
   input wire logic            drive_running,
   input wire logic            source_manual,
   input wire logic            run_cmd,
   input wire logic            run_execute,
   input wire logic            output_block,
   input wire logic [4:0]      fault_cause,
   input wire logic [14:0]     func_active
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_unmapped_error:
      assert property (psel && penable |->
         pslverr == (paddr > 8'h2C || paddr[1:0] != 2'h0))
      else $error("error response wrong for address");
   a_unmapped_zero:
      assert property (psel && !penable &&
         (paddr > 8'h2C || paddr[1:0] != 2'h0) |=> prdata == 0)
      else $error("unmapped read data not zero");
   a_rdata_holds:
      assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved outside setup");
   a_block_cause:
      assert property (output_block == (fault_cause != 5'h00))
      else $error("output block disagrees with fault cause");
   a_run_gate:
      assert property (!run_cmd |=> !run_execute)
      else $error("run executed without run command");
   a_manual_frozen:
      assert property (drive_running |=> $stable(source_manual))
      else $error("source changed while running");
   a_analog_source:
      assert property (!$stable(analog_freq) |->
         analog_freq == $past(voltage_analog_input) ||
         analog_freq == $past(current_analog_input))
      else $error("analog value from no input");
   a_hold_freeze:
      assert property ((analog_source && func_active[1]) [*2] |->
         $stable(analog_freq))
      else $error("analog value moved while held");
endmodule

bind mic_top mic_checker #(.AN_W(AN_W)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .voltage_analog_input(voltage_analog_input),
   .current_analog_input(current_analog_input),
   .analog_source(analog_source), .analog_freq(analog_freq),
   .drive_running(drive_running), .source_manual(source_manual),
   .run_cmd(run_cmd), .run_execute(run_execute),
   .output_block(output_block), .fault_cause(fault_cause),
   .func_active(func_active));
`default_nettype wire

// >>> verif/test_multifunction_input_conditioner.sv
`default_nettype none
module test_multifunction_input_conditioner;
   timeunit 1ns;
   timeprecision 1ns;
   import mic_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic        an_src, comb, cur_only, running, run_cmd, chatter, e;
   logic        manual, ramp, blk, warn, run_ex;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [14:0] cl, term_raw, func_active;
   logic [3:0]  key_raw, key_on;
   logic [11:0] volt, curr, afreq;
   logic [4:0]  cause;
   int          errors, samples_checked;

   always #50 pclk = ~pclk;

   mic_contacts u_contacts (.pclk(pclk), .closed(cl), .chatter(chatter),
      .term_raw(term_raw));
   mic_top #(.CYC_PER_MS(4)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .term_raw(term_raw), .keypad_raw(key_raw),
      .keypad_on(key_on), .voltage_analog_input(volt),
      .current_analog_input(curr), .analog_source(an_src),
      .combined_analog_mode(comb), .current_only_mode(cur_only),
      .drive_running(running), .run_cmd(run_cmd), .analog_freq(afreq),
      .source_manual(manual), .ramp_freeze(ramp), .output_block(blk),
      .fault_cause(cause), .transformer_heat_warning(warn),
      .run_execute(run_ex), .func_active(func_active));

   task automatic end_of_test;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask

   // Polls a state word, since filter delay depends on the tick phase
   task automatic settle(input logic [7:0] a, input logic [31:0] x);
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 32'h0);
         n++;
      end while (q !== x && n < 60);
      chk(q, x);
   endtask

   task automatic nap(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask

   initial begin
      #(20000 * 100);
      errors++;
      end_of_test;
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite, chatter} = 6'h00;
      {running, run_cmd, cur_only} = 3'h0;
      {an_src, comb} = 2'h3;
      paddr = 8'h00;
      pwdata = 32'h0;
      cl = 15'h0000;
      key_raw = 4'h0;
      volt = 12'h111;
      curr = 12'h222;
      errors = 0;
      samples_checked = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++)
         rd(8'(4 * i), i == 4 ? 32'hF : i == 5 ? 32'hA : 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, OFF_STATE_LOW, 32'h7FF);
      rd(OFF_STATE_LOW, 32'h0);
      apb(1'b1, OFF_FILT_MS, 32'h3E9);
      rd(OFF_FILT_MS, 32'h3E8);
      apb(1'b1, OFF_FILT_MS, 32'h1);
      rd(OFF_FILT_MS, 32'h2);
      apb(1'b1, OFF_VALID_MS, 32'h0);
      apb(1'b1, OFF_FUNC_LOW, 32'h98764321);
      apb(1'b1, OFF_FUNC_HIGH, 32'h00000DBA);
      apb(1'b1, OFF_POL_HIGH, 32'h7800);
      rd(OFF_POL_HIGH, 32'h7800);
      settle(OFF_STATE_HIGH, 32'h7800);
      rd(OFF_STATE_LOW, 32'h0);
      apb(1'b1, OFF_POL_HIGH, 32'h0);
      settle(OFF_STATE_HIGH, 32'h0);
      apb(1'b1, OFF_KEY_POL, 32'h5);
      key_raw <= 4'h3;
      nap(2);
      chk(32'(key_on), 32'h6);
      chk(32'(afreq), 32'h111);
      cl <= 15'h0002;
      settle(OFF_STATE_LOW, 32'h2);
      nap(2);
      chk(32'(afreq), 32'h222);
      cl <= 15'h0003;
      settle(OFF_STATE_LOW, 32'h3);
      curr <= 12'h444;
      nap(4);
      chk(32'(afreq), 32'h222);
      @(posedge pclk);
      an_src <= 1'b0;
      nap(2);
      chk(32'(afreq), 32'h444);
      @(posedge pclk);
      an_src <= 1'b1;
      curr <= 12'h555;
      nap(2);
      chk(32'(afreq), 32'h444);
      cl <= 15'h0002;
      settle(OFF_STATE_LOW, 32'h2);
      nap(2);
      chk(32'(afreq), 32'h555);
      @(posedge pclk);
      comb <= 1'b0;
      nap(2);
      chk(32'(afreq), 32'h111);
      @(posedge pclk);
      cur_only <= 1'b1;
      nap(2);
      chk(32'(afreq), 32'h555);
      @(posedge pclk);
      {comb, cur_only} <= 2'h2;
      cl <= 15'h0008;
      settle(OFF_STATE_LOW, 32'h8);
      nap(2);
      chk(32'(ramp), 32'h1);
      cl <= 15'h0004;
      settle(OFF_STATE_LOW, 32'h4);
      nap(2);
      chk(32'(manual), 32'h1);
      @(posedge pclk);
      running <= 1'b1;
      cl <= 15'h0000;
      settle(OFF_STATE_LOW, 32'h0);
      nap(2);
      chk(32'(manual), 32'h1);
      @(posedge pclk);
      running <= 1'b0;
      run_cmd <= 1'b1;
      nap(2);
      chk(32'(manual), 32'h0);
      chk(32'(run_ex), 32'h0);
      cl <= 15'h0400;
      settle(OFF_STATE_LOW, 32'h400);
      nap(2);
      chk(32'(run_ex), 32'h1);
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      cl <= 15'h0010;
      settle(OFF_STATE_LOW, 32'h10);
      nap(2);
      chk({warn, blk, irq}, 32'h4);
      apb(1'b1, OFF_IRQ_MASK, 32'h7);
      nap(0);
      chk(32'(irq), 32'h1);
      rd(OFF_IRQ_STATUS, 32'h5);
      nap(0);
      chk(32'(irq), 32'h0);
      for (int i = 0; i < 5; i++) begin
         cl <= 15'(32'h20 << i);
         settle(OFF_STATE_LOW, 32'h20 << i);
         apb(1'b0, OFF_IRQ_STATUS, 32'h0);
         nap(2);
         chk({blk, cause}, 32'h20 | (32'h1 << i));
         cl <= 15'h0000;
         settle(OFF_STATE_LOW, 32'h0);
         nap(2);
         chk(32'(blk), 32'h0);
      end
      chatter <= 1'b1;
      cl <= 15'h1000;
      nap(40);
      rd(OFF_STATE_HIGH, 32'h0);
      chatter <= 1'b0;
      settle(OFF_STATE_HIGH, 32'h1000);
      cl <= 15'h0000;
      settle(OFF_STATE_HIGH, 32'h0);
      apb(1'b1, OFF_VALID_MS, 32'h5);
      cl <= 15'h2000;
      nap(10);
      cl <= 15'h0000;
      nap(30);
      rd(OFF_STATE_HIGH, 32'h0);
      cl <= 15'h2000;
      nap(12);
      rd(OFF_STATE_HIGH, 32'h0);
      settle(OFF_STATE_HIGH, 32'h2000);
      end_of_test;
   end
endmodule
`default_nettype wire
